//--- sim/test_dsp_mac_unsigned_and_minmax.sv
// Purpose: Self-checking bench of the unsigned MAC and min/max search datapath
// Assumes: One AHB-Lite master, hready fed back from hreadyout
// Notes: Expected values come from the bench's own model functions
`include "dmac_params.svh"
`timescale 1ns/10ps
`default_nettype none
module test_dsp_mac_unsigned_and_minmax
	import dmac_pkg::*;
;
// ----------------------------------------
// Signals
// ----------------------------------------
logic hclk = 1'b0;
logic hresetn = 1'b0;
logic hsel = 1'b0;
logic hwrite = 1'b0;
logic [1:0] htrans = 2'h0;
logic [31:0] haddr = 32'h0;
logic [31:0] hwdata = 32'h0;
logic [31:0] hrdata;
logic hreadyout;
logic hresp;
int n_fail = 0;
int total_checks = 0;
int waits;
logic [31:0] lf = 32'h0001_33DB;
always #20 hclk = ~hclk;
dmac_core #(.MEM_AW(4)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
	.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
// ----------------------------------------
// Tasks and functions
// ----------------------------------------
function automatic logic [31:0] rnd();
	lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
	return lf;
endfunction
function automatic dmac_acc_t shp(logic [31:0] p, logic u, logic [1:0] ps, logic al);
	dmac_acc_t v;
	v = u ? {4'h0, p} : {{4{p[31]}}, p};
	case (ps)
		2'h1: v = v << 1;
		2'h2: v = v << 2;
		2'h3: v = dmac_acc_t'($signed(v) >>> 6);
		default: v = v;
	endcase
	if (al) begin
		v = dmac_acc_t'($signed(v) >>> 16);
	end
	return v;
endfunction
task automatic chk(input logic [35:0] s, input logic [35:0] e);
	total_checks++;
	if (s !== e) begin
		n_fail++;
		$display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
	end
endtask
task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
	output logic [31:0] r);
	logic ok;
	hsel <= 1'b1;
	htrans <= 2'h2;
	haddr <= {24'h0, a};
	hwrite <= w;
	do begin
		@(negedge hclk) ok = hreadyout;
		@(posedge hclk);
	end while (ok !== 1'b1);
	htrans <= 2'h0;
	hwdata <= d;
	waits = -1;
	do begin
		@(negedge hclk) ok = hreadyout;
		r = hrdata;
		waits++;
		@(posedge hclk);
	end while (ok !== 1'b1);
endtask
task automatic wacc(input logic s, input dmac_acc_t v);
	logic [31:0] r;
	xfer(1'b1, s ? `DMAC_A1_LO : `DMAC_A0_LO, v[31:0], r);
	xfer(1'b1, s ? `DMAC_A1_HI : `DMAC_A0_HI, {28'h0, v[35:32]}, r);
endtask
task automatic cacc(input logic s, input dmac_acc_t e);
	logic [31:0] lo, hi;
	xfer(1'b0, s ? `DMAC_A1_LO : `DMAC_A0_LO, 32'h0, lo);
	xfer(1'b0, s ? `DMAC_A1_HI : `DMAC_A0_HI, 32'h0, hi);
	chk({hi[3:0], lo}, e);
endtask
task print_verdict();
	$display("checks=%0d fails=%0d", total_checks, n_fail);
	if (n_fail == 0 && total_checks > 0)
		$display("TB: PASS");
	else
		$display("TB: FAIL");
	$finish;
endtask
initial begin
	repeat (50000) @(posedge hclk);
	n_fail++;
	print_verdict();
end
// ----------------------------------------
// Tests
// ----------------------------------------
initial begin
	logic [31:0] r, st, p, opnd;
	logic [15:0] xm[16], ym[16], y, x, r0;
	dmac_acc_t e[2], b;
	logic u, c, s, strict;
	logic [1:0] op, step, ps;
	int w[4], mixp;
	repeat (20) @(posedge hclk);
	hresetn <= 1'b1;
	@(posedge hclk);
	xfer(1'b0, `DMAC_STATUS, 32'h0, r);
	chk(r, 36'h0);
	xfer(1'b0, 8'h80, 32'h0, r);
	chk(r, 36'h0);
	chk(hresp, 36'h0);
	for (int k = 0; k < 16; k++) begin
		xm[k] = 16'(rnd());
		ym[k] = 16'(rnd());
		xfer(1'b1, `DMAC_MEM_ADDR, k, r);
		xfer(1'b1, `DMAC_XMEM_DATA, {16'h0, xm[k]}, r);
		xfer(1'b1, `DMAC_YMEM_DATA, {16'h0, ym[k]}, r);
	end
	xfer(1'b1, `DMAC_PTR0, 32'h3, r);
	xfer(1'b1, `DMAC_PTRI, 32'h5, r);
	xfer(1'b1, `DMAC_PTRJ, 32'h7, r);
	p = rnd() | 32'h8000_0000;
	xfer(1'b1, `DMAC_PROD_LO, {16'h0, p[15:0]}, r);
	xfer(1'b1, `DMAC_PROD_HI, {16'h0, p[31:16]}, r);
	u = 1'b0;
	for (int i = 0; i < 2; i++) begin
		e[i] = 36'({rnd(), rnd()});
		wacc(i[0], e[i]);
	end
	for (int f = 0; f < 4; f++) begin
		opnd = rnd();
		y = 16'(rnd());
		x = xm[3];
		ps = f[1:0];
		xfer(1'b1, `DMAC_OPERAND, opnd, r);
		xfer(1'b1, `DMAC_YREG, {16'h0, y}, r);
		xfer(1'b1, `DMAC_STATUS, {26'h0, f == 3, 3'h0, ps}, r);
		if (f == 1)
			x = opnd[15:0];
		if (f == 2) begin
			y = ym[7];
			x = xm[5];
		end
		if (f == 3) begin
			y = xm[3];
			x = opnd[31:16];
		end
		e[f % 2] = e[f % 2] + shp(p, u, ps, f == 3);
		p = y * x;
		u = 1'b1;
		xfer(1'b1, `DMAC_CMD, {26'h0, f[1:0], f[0], 3'h0}, r);
		// Cycles the command stays busy after its write completes
		w[f] = 0;
		#1;
		while (DUT.busy === 1'b1) begin
			w[f]++;
			@(posedge hclk);
			#1;
		end
		xfer(1'b0, `DMAC_STATUS, 32'h0, st);
		chk(st[`DMAC_ST_UNS], 36'h1);
		chk({st[`DMAC_ST_NFLAG], st[`DMAC_ST_ZFLAG]}, {e[f % 2][35], e[f % 2] == 36'h0});
		cacc(f[0], e[f % 2]);
		xfer(1'b0, `DMAC_PROD_LO, 32'h0, r);
		xfer(1'b0, `DMAC_PROD_HI, 32'h0, st);
		chk({st[15:0], r[15:0]}, p);
		xfer(1'b0, `DMAC_YREG, 32'h0, r);
		chk(r[15:0], y);
		xfer(1'b0, `DMAC_XREG, 32'h0, r);
		chk(r[15:0], x);
	end
	chk(w[3], w[1] + 1);
	xfer(1'b1, `DMAC_PROD_HI, 32'h0, r);
	xfer(1'b0, `DMAC_STATUS, 32'h0, st);
	chk(st[`DMAC_ST_UNS], 36'h0);
	mixp = 0;
	for (int i = 0; i < 24; i++) begin
		op = 2'(1 + i % 3);
		r = rnd();
		{strict, s, step, ps} = r[5:0];
		r0 = {12'h0, r[9:6]};
		for (int k = 0; k < 2; k++) begin
			r = rnd();
			e[k] = {{19{r[16]}}, r[16:0]};
		end
		b = op == 2'h2 ? {{20{xm[r0][15]}}, xm[r0]} : e[!s];
		if (i % 4 == 0)
			e[s] = b;
		wacc(1'b0, e[0]);
		wacc(1'b1, e[1]);
		xfer(1'b1, `DMAC_PTR0, {16'h0, r0}, st);
		xfer(1'b1, `DMAC_STATUS, {29'h0, r[20], ps}, r);
		xfer(1'b0, `DMAC_STATUS, 32'h0, p);
		xfer(1'b1, `DMAC_CMD, {24'h0, step, 2'h0, s, strict, op}, r);
		c = e[s] == b ? !strict : (op == 2'h1) == ($signed(e[s]) > $signed(b));
		if (c) begin
			e[s] = b;
			mixp = r0;
		end
		cacc(1'b0, e[0]);
		cacc(1'b1, e[1]);
		xfer(1'b0, `DMAC_MIXP, 32'h0, r);
		chk(r[15:0], mixp);
		xfer(1'b0, `DMAC_PTR0, 32'h0, r);
		chk(r[15:0], 16'(r0 + {{14{step[1]}}, step}));
		xfer(1'b0, `DMAC_STATUS, 32'h0, st);
		chk(st[`DMAC_ST_MFLAG], c);
		chk({st[7:3], st[1:0]}, {p[7:3], p[1:0]});
	end
	print_verdict();
end
endmodule
`default_nettype wire

//--- verilog/dmac_core.sv
// Purpose: Unsigned MAC and min/max search datapath behind an AHB-Lite slave
// Assumes: Single-word transfers, one slave, hready fed from hreadyout
// Notes: Every access has one wait state; accesses stall while a command runs
// Operation
// [RULE1] Unsigned MAC adds shifted old product to the chosen accumulator, loads Y and X, forms Y*X.
// [RULE2] Unsigned MAC runs one cycle, or two when the second operand is a long immediate.
// [RULE3] The old product is extended to 36 bits and shifted by the product shift field.
// [RULE4] Software must not name an accumulator or the product as the register operand.
// [RULE5] Dual-pointer form reads Y from Y memory by the J pointer and X from X memory by I.
// [RULE6] After an unsigned MAC the product is zero-extended until the high word is rewritten.
// [RULE7] Software should save the product in handlers and mask interrupts around its use.
// [RULE8] Accumulator max copies the other accumulator and pointer zero when the test holds.
// [RULE9] Memory max loads the word at pointer zero and captures pointer zero when larger, or when equal if not strict.
// [RULE10] Accumulator min updates the chosen accumulator and captures pointer zero on the test.
// [RULE11] All search commands post-modify pointer zero whether or not an update happened.
// [RULE12] Max commands set the minus-position flag on update, clear it otherwise, keep others.
// [RULE13] The min command sets the minus-position flag on update, clears it otherwise.
// [RULE14] Software must not read the index capture right after a search command.
// [RULE15] The aligned form moves the shifted product 16 bits right with sign extension.
// [RULE16] Search compares are signed, memory words sign-extended to accumulator width.
`include "dmac_params.svh"
`timescale 1ns/10ps
`default_nettype none
module dmac_core
	import dmac_pkg::*;
#(
	parameter int MEM_AW = 4
) (
	// Clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp
);
	localparam int MEM_DEPTH = 1 << MEM_AW;

	typedef struct packed {
		dmac_state_e state;
		logic ap_valid;
		logic ap_write;
		logic [7:0] ap_addr;
		logic hready_q;
		logic [31:0] hrdata_q;
		logic [7:0] cmd;
		logic [1:0] ps;
		logic align;
		logic mflag;
		logic zflag;
		logic nflag;
		logic uns;
		logic [15:0] x;
		logic [15:0] y;
		logic [31:0] prod;
		logic [1:0][35:0] acc;
		logic [15:0] r0;
		logic [15:0] ri;
		logic [15:0] rj;
		logic [15:0] mixp;
		logic [31:0] operand;
		logic [MEM_AW-1:0] mem_addr;
		logic [MEM_DEPTH-1:0][15:0] xmem;
		logic [MEM_DEPTH-1:0][15:0] ymem;
	} dmac_state_s;

	dmac_state_s st_q;
	dmac_state_s st_d;

	// ----------------------------------------
	// Product source shaping
	// ----------------------------------------
	function automatic dmac_acc_t shift_prod(input logic [31:0] p, input logic [1:0] ps,
		input logic uns, input logic align);
		dmac_acc_t ext;
		dmac_acc_t sh;
		ext = uns ? {4'h0, p} : {{4{p[31]}}, p}; // RULE3 RULE6
		unique case (ps)
			`DMAC_PS_NONE: sh = ext;
			`DMAC_PS_LEFT1: sh = ext << 1;
			`DMAC_PS_LEFT2: sh = ext << 2;
			`DMAC_PS_RIGHT6: sh = dmac_acc_t'($signed(ext) >>> `DMAC_RIGHT6);
		endcase
		if (align) begin
			sh = dmac_acc_t'($signed(sh) >>> `DMAC_ALIGN_SHIFT); // RULE15
		end
		return sh;
	endfunction

	function automatic logic [MEM_AW-1:0] mem_idx(input logic [15:0] ptr);
		return ptr[MEM_AW-1:0];
	endfunction

	// ----------------------------------------
	// Command decode and operands
	// ----------------------------------------
	logic [1:0] c_op;
	logic c_strict;
	logic c_sel;
	logic [1:0] c_form;
	logic [15:0] c_step;
	logic busy;
	logic [15:0] ex_y;
	logic [15:0] ex_x;
	dmac_acc_t sp;
	dmac_acc_t own_acc;
	dmac_acc_t oth_acc;
	dmac_acc_t mem_word;
	logic upd;
	logic exec_search;

	assign c_op = st_q.cmd[1:0];
	assign c_strict = st_q.cmd[2];
	assign c_sel = st_q.cmd[3];
	assign c_form = st_q.cmd[5:4];
	assign c_step = {{14{st_q.cmd[7]}}, st_q.cmd[7:6]};
	assign busy = st_q.state != ST_IDLE;
	assign sp = shift_prod(st_q.prod, st_q.ps, st_q.uns, st_q.align);
	assign own_acc = st_q.acc[c_sel];
	assign oth_acc = st_q.acc[~c_sel];
	assign mem_word = {{20{st_q.xmem[mem_idx(st_q.r0)][15]}}, st_q.xmem[mem_idx(st_q.r0)]}; // RULE16
	assign exec_search = st_q.state == ST_EXEC && c_op != `DMAC_OP_MACUU;

	always_comb begin
		ex_y = st_q.y;
		ex_x = st_q.xmem[mem_idx(st_q.r0)];
		unique case (c_form)
			`DMAC_FORM_PTR: ex_x = st_q.xmem[mem_idx(st_q.r0)];
			`DMAC_FORM_REG: ex_x = st_q.operand[15:0];
			`DMAC_FORM_DUAL: begin
				ex_y = st_q.ymem[mem_idx(st_q.rj)]; // RULE5
				ex_x = st_q.xmem[mem_idx(st_q.ri)]; // RULE5
			end
			`DMAC_FORM_IMM: begin
				ex_y = st_q.xmem[mem_idx(st_q.r0)];
				ex_x = st_q.operand[31:16];
			end
		endcase
	end

	always_comb begin
		upd = 1'b0;
		unique case (c_op)
			`DMAC_OP_MACUU: upd = 1'b0;
			`DMAC_OP_MAX: upd = c_strict ? $signed(own_acc) > $signed(oth_acc)
				: $signed(own_acc) >= $signed(oth_acc); // RULE8
			`DMAC_OP_MAXD: upd = c_strict ? $signed(mem_word) > $signed(own_acc)
				: $signed(mem_word) >= $signed(own_acc); // RULE9
			`DMAC_OP_MIN: upd = c_strict ? $signed(own_acc) < $signed(oth_acc)
				: $signed(own_acc) <= $signed(oth_acc); // RULE10
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		// Address phase capture
		if (hready) begin
			st_d.ap_valid = hsel & htrans[1];
			st_d.ap_write = hwrite;
			st_d.ap_addr = haddr[7:0];
			st_d.hready_q = ~(hsel & htrans[1]);
		end
		// Data phase, held off while a command runs
		if (st_q.ap_valid && !st_q.hready_q && !busy) begin
			st_d.ap_valid = 1'b0;
			st_d.hready_q = 1'b1;
			st_d.hrdata_q = 32'h0000_0000;
			if (st_q.ap_write) begin
				unique case (st_q.ap_addr)
					`DMAC_CMD: begin
						st_d.cmd = hwdata[7:0];
						st_d.state = (hwdata[1:0] == `DMAC_OP_MACUU
							&& hwdata[5:4] == `DMAC_FORM_IMM) ? ST_FETCH : ST_EXEC; // RULE2
					end
					`DMAC_STATUS: begin
						st_d.ps = hwdata[1:0];
						st_d.mflag = hwdata[`DMAC_ST_MFLAG];
						st_d.align = hwdata[`DMAC_ST_ALIGN];
					end
					`DMAC_XREG: st_d.x = hwdata[15:0];
					`DMAC_YREG: st_d.y = hwdata[15:0];
					`DMAC_PROD_LO: st_d.prod[15:0] = hwdata[15:0];
					`DMAC_PROD_HI: begin
						st_d.prod[31:16] = hwdata[15:0];
						st_d.uns = 1'b0; // RULE6
					end
					`DMAC_A0_LO: st_d.acc[0][31:0] = hwdata;
					`DMAC_A0_HI: st_d.acc[0][35:32] = hwdata[3:0];
					`DMAC_A1_LO: st_d.acc[1][31:0] = hwdata;
					`DMAC_A1_HI: st_d.acc[1][35:32] = hwdata[3:0];
					`DMAC_PTR0: st_d.r0 = hwdata[15:0];
					`DMAC_PTRI: st_d.ri = hwdata[15:0];
					`DMAC_PTRJ: st_d.rj = hwdata[15:0];
					`DMAC_MIXP: st_d.mixp = hwdata[15:0];
					`DMAC_OPERAND: st_d.operand = hwdata;
					`DMAC_MEM_ADDR: st_d.mem_addr = hwdata[MEM_AW-1:0];
					`DMAC_XMEM_DATA: st_d.xmem[st_q.mem_addr] = hwdata[15:0];
					`DMAC_YMEM_DATA: st_d.ymem[st_q.mem_addr] = hwdata[15:0];
					default: st_d.hrdata_q = 32'h0000_0000;
				endcase
			end else begin
				unique case (st_q.ap_addr)
					`DMAC_CMD: st_d.hrdata_q = {24'h00_0000, st_q.cmd};
					`DMAC_STATUS: st_d.hrdata_q = {24'h00_0000, st_q.nflag, st_q.zflag,
						st_q.align, busy, st_q.uns, st_q.mflag, st_q.ps};
					`DMAC_XREG: st_d.hrdata_q = {16'h0000, st_q.x};
					`DMAC_YREG: st_d.hrdata_q = {16'h0000, st_q.y};
					`DMAC_PROD_LO: st_d.hrdata_q = {16'h0000, st_q.prod[15:0]};
					`DMAC_PROD_HI: st_d.hrdata_q = {16'h0000, st_q.prod[31:16]};
					`DMAC_A0_LO: st_d.hrdata_q = st_q.acc[0][31:0];
					`DMAC_A0_HI: st_d.hrdata_q = {28'h000_0000, st_q.acc[0][35:32]};
					`DMAC_A1_LO: st_d.hrdata_q = st_q.acc[1][31:0];
					`DMAC_A1_HI: st_d.hrdata_q = {28'h000_0000, st_q.acc[1][35:32]};
					`DMAC_PTR0: st_d.hrdata_q = {16'h0000, st_q.r0};
					`DMAC_PTRI: st_d.hrdata_q = {16'h0000, st_q.ri};
					`DMAC_PTRJ: st_d.hrdata_q = {16'h0000, st_q.rj};
					`DMAC_MIXP: st_d.hrdata_q = {16'h0000, st_q.mixp};
					`DMAC_OPERAND: st_d.hrdata_q = st_q.operand;
					`DMAC_MEM_ADDR: st_d.hrdata_q = 32'(st_q.mem_addr);
					`DMAC_XMEM_DATA: st_d.hrdata_q = {16'h0000, st_q.xmem[st_q.mem_addr]};
					`DMAC_YMEM_DATA: st_d.hrdata_q = {16'h0000, st_q.ymem[st_q.mem_addr]};
					default: st_d.hrdata_q = 32'h0000_0000;
				endcase
			end
		end
		// Command execution
		unique case (st_q.state)
			ST_IDLE: ;
			ST_FETCH: st_d.state = ST_EXEC; // RULE2
			ST_EXEC: begin
				st_d.state = ST_IDLE;
				if (c_op == `DMAC_OP_MACUU) begin
					st_d.acc[c_sel] = own_acc + sp; // RULE1
					st_d.y = ex_y; // RULE1
					st_d.x = ex_x; // RULE1
					st_d.prod = {16'h0000, ex_y} * {16'h0000, ex_x}; // RULE1
					st_d.uns = 1'b1; // RULE6
					st_d.zflag = (own_acc + sp) == 36'h0_0000_0000;
					st_d.nflag = st_d.acc[c_sel][35];
				end else begin
					if (upd) begin
						st_d.acc[c_sel] = (c_op == `DMAC_OP_MAXD) ? mem_word : oth_acc; // RULE8 RULE9 RULE10
						st_d.mixp = st_q.r0; // RULE8 RULE9 RULE10
					end
					st_d.mflag = upd; // RULE12 RULE13
					st_d.r0 = st_q.r0 + c_step; // RULE11
				end
			end
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			st_q <= '0;
			st_q.state <= ST_IDLE;
			st_q.hready_q <= `DMAC_RESET_HREADY;
		end else begin
			st_q <= st_d;
		end
	end

	assign hrdata = st_q.hrdata_q;
	assign hreadyout = st_q.hready_q;
	assign hresp = 1'b0;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	imm_two_cycle_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE2
		(st_q.state == ST_IDLE && st_d.state == ST_FETCH) |=> st_q.state == ST_FETCH ##1
		st_q.state == ST_EXEC ##1 st_q.state == ST_IDLE)
		else $error("long immediate command not two cycles");
	mac_product_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE1
		(st_q.state == ST_EXEC && c_op == `DMAC_OP_MACUU) |=>
		st_q.prod == {16'h0000, $past(ex_y)} * {16'h0000, $past(ex_x)} && st_q.uns)
		else $error("unsigned product wrong");
	mac_accum_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE3
		(st_q.state == ST_EXEC && c_op == `DMAC_OP_MACUU) |=>
		st_q.acc[$past(c_sel)] == $past(own_acc) + $past(sp))
		else $error("accumulate of shifted product wrong");
	zero_ext_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE6
		(st_q.uns && st_q.ps == `DMAC_PS_NONE && !st_q.align) |-> sp[35:32] == 4'h0)
		else $error("unsigned product not zero extended");
	dual_ptr_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE5
		(st_q.state == ST_EXEC && c_form == `DMAC_FORM_DUAL && c_op == `DMAC_OP_MACUU) |=>
		st_q.y == $past(st_q.ymem[mem_idx(st_q.rj)]) && st_q.x == $past(st_q.xmem[mem_idx(st_q.ri)]))
		else $error("dual pointer operands wrong");
	search_capture_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE8
		(exec_search && upd) |=> st_q.mixp == $past(st_q.r0) && st_q.mflag)
		else $error("search update did not capture pointer");
	search_keep_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE12
		(exec_search && !upd) |=> !st_q.mflag && $stable(st_q.acc) && $stable(st_q.mixp)
		&& $stable(st_q.zflag) && $stable(st_q.nflag))
		else $error("search without update changed state");
	post_modify_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE11
		exec_search |=> st_q.r0 == 16'($past(st_q.r0) + $past(c_step)))
		else $error("pointer zero not post modified");
	min_value_a: assert property (@(posedge hclk) disable iff (!hresetn) // RULE10
		(exec_search && c_op == `DMAC_OP_MIN && upd) |=> st_q.acc[$past(c_sel)] == $past(oth_acc))
		else $error("min did not take other accumulator");
	bus_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
		(hready && hsel && htrans[1]) |=> !hreadyout ##1 (hreadyout || busy))
		else $error("data phase wait state wrong");
endmodule
`default_nettype wire

//--- verilog/dmac_params.svh
// Purpose: Offsets, field positions, reset values and shift codes of the MAC/search datapath
// Assumes: Byte addresses on a 32-bit AHB-Lite bus
// Notes: Definitions only
`ifndef DMAC_PARAMS_SVH
`define DMAC_PARAMS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define DMAC_CMD 8'h00
`define DMAC_STATUS 8'h04
`define DMAC_XREG 8'h08
`define DMAC_YREG 8'h0C
`define DMAC_PROD_LO 8'h10
`define DMAC_PROD_HI 8'h14
`define DMAC_A0_LO 8'h18
`define DMAC_A0_HI 8'h1C
`define DMAC_A1_LO 8'h20
`define DMAC_A1_HI 8'h24
`define DMAC_PTR0 8'h28
`define DMAC_PTRI 8'h2C
`define DMAC_PTRJ 8'h30
`define DMAC_MIXP 8'h34
`define DMAC_OPERAND 8'h38
`define DMAC_MEM_ADDR 8'h3C
`define DMAC_XMEM_DATA 8'h40
`define DMAC_YMEM_DATA 8'h44
// ----------------------------------------
// Command fields
// ----------------------------------------
`define DMAC_OP_MACUU 2'h0
`define DMAC_OP_MAX 2'h1
`define DMAC_OP_MAXD 2'h2
`define DMAC_OP_MIN 2'h3
`define DMAC_FORM_PTR 2'h0
`define DMAC_FORM_REG 2'h1
`define DMAC_FORM_DUAL 2'h2
`define DMAC_FORM_IMM 2'h3
// ----------------------------------------
// Status fields and product shift codes
// ----------------------------------------
`define DMAC_ST_MFLAG 2
`define DMAC_ST_UNS 3
`define DMAC_ST_BUSY 4
`define DMAC_ST_ALIGN 5
`define DMAC_ST_ZFLAG 6
`define DMAC_ST_NFLAG 7
`define DMAC_PS_NONE 2'h0
`define DMAC_PS_LEFT1 2'h1
`define DMAC_PS_LEFT2 2'h2
`define DMAC_PS_RIGHT6 2'h3
`define DMAC_RIGHT6 6
`define DMAC_ALIGN_SHIFT 16
`define DMAC_RESET_HREADY 1'b1
`endif

//--- verilog/dmac_pkg.sv
// Purpose: Types of the MAC/search datapath
// Assumes: Used with dmac_params.svh
// Notes: Types only
package dmac_pkg;
	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} dmac_state_e;
	typedef logic [35:0] dmac_acc_t;
endpackage
